/* design/mps_ctl_end.sv */
// control station: polling scheduler, error counters and apb register file
//
// Contract
// - valid data reply returns tributary to active
// - transmit buffer assignment makes tributary active
// - no poll before inter-poll delay elapses
// - host loads polling parameters via slot writes
// - update period defaults 200 ms, never below
// - eligible only at urgency 128 or more
// - equal defaults, all active: round-robin
// - transmission suspended while poll delay runs
// - poll delay starts at tributary deselect
// - default poll delay zero, no spacing
// - one dead tributary per dead-timer expiry
// - dead timer defaults to ten seconds
// - every station keeps error counters
// - nak carries address and reason code
// - detected error answered with nak to sender
// - count naks both sent and received
// - per-tributary counters in tributary slot
// - one station counter set per link
// - counters saturate until explicitly cleared; tributary-side counters clear only at reset
// - each period add increment, limit 255
// - scan after last polled, highest wins, 255 stops
// - polled urgency reverts to state initial value
// - demote on nodata and timeout runs
//
// Chosen here: the APB interface to the registers and the placing of the registers.
module mps_ctl_end #(
  parameter int P_TICK_CYC = mps_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // line
  mps_link_if.ctl          lnk
);
  localparam int N  = mps_pkg::N_TRIB;
  localparam int TW = mps_pkg::TW;

  logic [23:0]          q_q [N];
  logic [23:0]          r_q [N];
  logic [23:0]          lim_q [N];
  logic [7:0]           urg_q [N];
  logic [7:0]           nsent_q [N];
  logic [7:0]           nrcvd_q [N];
  logic [7:0]           seltmo_q [N];
  mps_pkg::mps_pstate_t ps_q [N];
  logic                 en_q;
  logic [15:0]          delta_q, pdly_q, dead_q, g_selto_q;
  logic [15:0]          dlt_ms_q, dd_ms_q, ms_q;
  logic [31:0]          pre_q, sub_q;
  logic [7:0]           stn_mis_q, stn_unk_q;
  logic [TW-1:0]        last_q, last_dead_q, sel_q;
  logic                 dead_due_q;
  mps_pkg::mps_sched_t  st_q, st_d;
  logic [31:0]          rd_d, prdata_q;
  logic                 poll_q, nak_q;
  logic [TW-1:0]        poll_addr_q, nak_addr_q;
  logic [7:0]           nak_rsn_q;
  logic [TW-1:0]        pick, dpick;
  logic                 found, dfound;
  logic [7:0]           best;

  function automatic int lvl_pos(input mps_pkg::mps_pstate_t s);
    case (s)
      mps_pkg::PS_ACTIVE: lvl_pos = mps_pkg::F_LVL0;
      mps_pkg::PS_IDLE:   lvl_pos = mps_pkg::F_LVL1;
      default:            lvl_pos = mps_pkg::F_LVL2;
    endcase
  endfunction : lvl_pos

  // saturating count with clear; an event in the clear cycle survives
  function automatic logic [7:0] cnt8(input logic [7:0] v, input logic clr, input logic inc);
    logic [7:0] b;
    b = clr ? 8'h00 : v;
    cnt8 = (inc && b != 8'hff) ? b + 8'h01 : b;
  endfunction : cnt8

  // apb decode
  wire          setup   = i_psel & ~i_penable;
  wire          acc     = i_psel & i_penable;
  wire          aligned = i_paddr[1:0] == 2'h0;
  wire [TW-1:0] a_tr    = i_paddr[7:4];
  wire [1:0]    a_wd    = i_paddr[3:2];
  wire          slot_ok = aligned & (i_paddr[11:8] == mps_pkg::REGION_SLOT) & (a_tr < TW'(N));
  wire          g_ok    = aligned & (i_paddr[11:8] == mps_pkg::REGION_GLB)
                          & (i_paddr <= mps_pkg::G_SCHED);
  wire          wr      = acc & i_pwrite & (slot_ok | g_ok);
  wire          wr_slot = wr & slot_ok;
  wire          wr_buf  = wr & (i_paddr == mps_pkg::G_BUF);
  wire          wr_stn  = wr & (i_paddr == mps_pkg::G_STN);
  assign o_pready  = acc;
  assign o_pslverr = acc & ~(slot_ok | g_ok);
  assign o_prdata  = prdata_q;

  // timer ticks
  wire tick     = pre_q == 32'(P_TICK_CYC - 1);
  wire upd_tick = tick & (dlt_ms_q + 16'h0001 >= delta_q);
  wire dead_tick = tick & (dd_ms_q + 16'h0001 >= dead_q);
  wire sub_wrap = sub_q == 32'(P_TICK_CYC - 1);

  // scheduler events
  wire in_wait  = st_q == mps_pkg::SC_WAIT;
  wire in_sel   = st_q == mps_pkg::SC_SEL;
  wire in_gap   = st_q == mps_pkg::SC_GAP;
  wire sel_tmo  = in_sel & ~lnk.rsp & (ms_q >= g_selto_q);
  wire fin      = in_sel & (lnk.rsp | sel_tmo);
  wire dead_go  = dead_due_q & dfound;
  wire issue    = in_wait & en_q & (dead_go | found);
  wire [TW-1:0] iss_idx = dead_go ? dpick : pick;

  // highest urgency after the last polled; strict compare keeps scan order on ties
  always_comb begin
    int j;
    j     = 0;
    found = 1'b0;
    pick  = '0;
    best  = '0;
    for (int k = 1; k <= N; k++) begin
      j = (int'(last_q) + k) % N;
      if (ps_q[j] != mps_pkg::PS_LOST && urg_q[j] >= mps_pkg::URG_THR
          && (!found || urg_q[j] > best)) begin
        found = 1'b1;
        pick  = TW'(j);
        best  = urg_q[j];
      end
    end
  end

  // next dead tributary after the last dead one polled
  always_comb begin
    int j;
    j      = 0;
    dfound = 1'b0;
    dpick  = '0;
    for (int k = 1; k <= N; k++) begin
      j = (int'(last_dead_q) + k) % N;
      if (!dfound && ps_q[j] == mps_pkg::PS_LOST) begin
        dfound = 1'b1;
        dpick  = TW'(j);
      end
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      mps_pkg::SC_WAIT: if (issue) st_d = mps_pkg::SC_SEL;
      mps_pkg::SC_SEL:  if (fin) st_d = (pdly_q == 16'h0000) ? mps_pkg::SC_WAIT
                                                              : mps_pkg::SC_GAP;
      mps_pkg::SC_GAP:  if (ms_q >= pdly_q) st_d = mps_pkg::SC_WAIT;
      default:          st_d = mps_pkg::SC_WAIT;
    endcase
  end

  // register read mux
  always_comb begin
    rd_d = 32'h0;
    if (slot_ok) begin
      case (a_wd)
        mps_pkg::SLOT_Q:   rd_d = {8'h00, q_q[a_tr]};
        mps_pkg::SLOT_R:   rd_d = {8'h00, r_q[a_tr]};
        mps_pkg::SLOT_LIM: rd_d = {4'h0, ps_q[a_tr], lim_q[a_tr]};
        default:           rd_d = {seltmo_q[a_tr], nrcvd_q[a_tr], nsent_q[a_tr], urg_q[a_tr]};
      endcase
    end else begin
      case (i_paddr)
        mps_pkg::G_CTRL:  rd_d = {31'h0, en_q};
        mps_pkg::G_DELTA: rd_d = {16'h0, delta_q};
        mps_pkg::G_PDLY:  rd_d = {16'h0, pdly_q};
        mps_pkg::G_DEAD:  rd_d = {16'h0, dead_q};
        mps_pkg::G_SELTO: rd_d = {16'h0, g_selto_q};
        mps_pkg::G_STN:   rd_d = {16'h0, stn_unk_q, stn_mis_q};
        mps_pkg::G_SCHED: rd_d = {23'h0, dead_due_q, 1'b0, st_q, last_q};
        default:          rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_q  <= 32'h0;
      en_q      <= mps_pkg::EN_DEF;
      delta_q   <= mps_pkg::DELTA_T_DEF;
      pdly_q    <= mps_pkg::PDLY_DEF;
      dead_q    <= mps_pkg::DEAD_T_DEF;
      g_selto_q <= mps_pkg::SEL_TO_DEF;
    end else begin
      if (setup) prdata_q <= rd_d;
      if (wr && i_paddr == mps_pkg::G_CTRL) en_q <= i_pwdata[mps_pkg::CTRL_EN];
      if (wr && i_paddr == mps_pkg::G_DELTA)
        delta_q <= (i_pwdata[15:0] < mps_pkg::DELTA_T_MIN) ? mps_pkg::DELTA_T_MIN
                                                           : i_pwdata[15:0];
      if (wr && i_paddr == mps_pkg::G_PDLY) pdly_q <= i_pwdata[15:0];
      if (wr && i_paddr == mps_pkg::G_DEAD) dead_q <= i_pwdata[15:0];
      if (wr && i_paddr == mps_pkg::G_SELTO) g_selto_q <= i_pwdata[15:0];
    end
  end

  // prescaler and free-running period timers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q    <= 32'h0;
      dlt_ms_q <= 16'h0;
      dd_ms_q  <= 16'h0;
    end else begin
      pre_q    <= tick ? 32'h0 : pre_q + 32'h1;
      dlt_ms_q <= upd_tick ? 16'h0 : (tick ? dlt_ms_q + 16'h0001 : dlt_ms_q);
      dd_ms_q  <= dead_tick ? 16'h0 : (tick ? dd_ms_q + 16'h0001 : dd_ms_q);
    end
  end

  // scheduler state, selection and gap timer restarted on every state entry
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q        <= mps_pkg::SC_WAIT;
      sub_q       <= 32'h0;
      ms_q        <= 16'h0;
      sel_q       <= '0;
      last_q      <= TW'(N - 1);
      last_dead_q <= TW'(N - 1);
      dead_due_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      sub_q      <= (st_d != st_q || sub_wrap) ? 32'h0 : sub_q + 32'h1;
      ms_q       <= (st_d != st_q) ? 16'h0 : ((sub_wrap && ms_q != 16'hffff) ? ms_q + 16'h0001
                                                                           : ms_q);
      dead_due_q <= (dead_tick & dfound) | (dead_due_q & ~(issue & dead_go));
      if (issue) begin
        sel_q <= iss_idx;
        if (dead_go) last_dead_q <= dpick;
        else last_q <= pick;
      end
    end
  end

  // line outputs; hold toward tributaries during the poll gap
  assign lnk.tx_hold       = in_gap;
  assign lnk.poll          = poll_q;
  assign lnk.poll_addr     = poll_addr_q;
  assign lnk.nak_dn        = nak_q;
  assign lnk.nak_dn_addr   = nak_addr_q;
  assign lnk.nak_dn_reason = nak_rsn_q;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      poll_q      <= 1'b0;
      poll_addr_q <= '0;
      nak_q       <= 1'b0;
      nak_addr_q  <= '0;
      nak_rsn_q   <= 8'h00;
      stn_mis_q   <= 8'h00;
      stn_unk_q   <= 8'h00;
    end else begin
      poll_q <= issue;
      if (issue) poll_addr_q <= iss_idx;
      nak_q <= in_sel & lnk.rsp & (lnk.rsp_kind == mps_pkg::RSP_ERR);
      if (in_sel & lnk.rsp) begin
        nak_addr_q <= sel_q;
        nak_rsn_q  <= lnk.rsp_reason;
      end
      stn_mis_q <= cnt8(stn_mis_q, wr_stn, in_sel & lnk.rsp & (lnk.rsp_addr != sel_q));
      stn_unk_q <= cnt8(stn_unk_q, wr_stn, lnk.nak_up & (lnk.nak_up_addr >= TW'(N)));
    end
  end

  // per-tributary slot: parameters, urgency, polling state, counters
  for (genvar i = 0; i < N; i++) begin : g_tr
    logic [7:0] nd_run_q, to_run_q;
    wire        me      = wr_slot & (a_tr == TW'(i));
    wire        me_sel  = fin & (sel_q == TW'(i));
    wire        f_data  = me_sel & lnk.rsp & (lnk.rsp_kind == mps_pkg::RSP_DATA);
    wire        f_nod   = me_sel & lnk.rsp & (lnk.rsp_kind == mps_pkg::RSP_NODATA);
    wire        f_to    = me_sel & sel_tmo;
    wire        buf_me  = wr_buf & (i_pwdata[TW-1:0] == TW'(i));
    wire        polled  = issue & (iss_idx == TW'(i));
    wire [8:0]  nd_nxt  = {1'b0, nd_run_q} + 9'h001;
    wire [8:0]  to_nxt  = {1'b0, to_run_q} + 9'h001;
    wire [8:0]  urg_sum = {1'b0, urg_q[i]} + {1'b0, r_q[i][lvl_pos(ps_q[i]) +: mps_pkg::FW]};

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        q_q[i]      <= mps_pkg::Q_DEF;
        r_q[i]      <= mps_pkg::R_DEF;
        lim_q[i]    <= mps_pkg::LIM_DEF;
        urg_q[i]    <= mps_pkg::Q_DEF[mps_pkg::F_LVL0 +: mps_pkg::FW];
        ps_q[i]     <= mps_pkg::PS_ACTIVE;
        nd_run_q    <= 8'h00;
        to_run_q    <= 8'h00;
        nsent_q[i]  <= 8'h00;
        nrcvd_q[i]  <= 8'h00;
        seltmo_q[i] <= 8'h00;
      end else begin
        if (me && a_wd == mps_pkg::SLOT_Q) q_q[i] <= i_pwdata[23:0];
        if (me && a_wd == mps_pkg::SLOT_R) r_q[i] <= i_pwdata[23:0];
        if (me && a_wd == mps_pkg::SLOT_LIM) lim_q[i] <= i_pwdata[23:0];
        if (polled)
          urg_q[i] <= q_q[i][lvl_pos(ps_q[i]) +: mps_pkg::FW];
        else if (upd_tick && ps_q[i] != mps_pkg::PS_LOST)
          urg_q[i] <= urg_sum[8] ? mps_pkg::URG_MAX : urg_sum[7:0];
        if (buf_me) begin
          ps_q[i]  <= mps_pkg::PS_ACTIVE;
          nd_run_q <= 8'h00;
          to_run_q <= 8'h00;
        end else if (f_data || (f_nod && ps_q[i] == mps_pkg::PS_LOST)) begin
          ps_q[i]  <= mps_pkg::PS_ACTIVE;
          nd_run_q <= 8'h00;
          to_run_q <= 8'h00;
        end else if (f_nod) begin
          to_run_q <= 8'h00;
          if (ps_q[i] == mps_pkg::PS_ACTIVE) begin
            nd_run_q <= nd_nxt[8] ? 8'hff : nd_nxt[7:0];
            if (nd_nxt >= {1'b0, lim_q[i][mps_pkg::F_LVL0 +: mps_pkg::FW]}) begin
              ps_q[i]  <= mps_pkg::PS_IDLE;
              nd_run_q <= 8'h00;
            end
          end
        end else if (f_to) begin
          nd_run_q <= 8'h00;
          to_run_q <= to_nxt[8] ? 8'hff : to_nxt[7:0];
          if ((ps_q[i] == mps_pkg::PS_ACTIVE || ps_q[i] == mps_pkg::PS_IDLE)
              && to_nxt >= {1'b0, lim_q[i][mps_pkg::F_LVL1 +: mps_pkg::FW]}) begin
            ps_q[i]  <= mps_pkg::PS_SILENT;
            to_run_q <= 8'h00;
          end else if (ps_q[i] == mps_pkg::PS_SILENT
                       && to_nxt > {1'b0, lim_q[i][mps_pkg::F_LVL2 +: mps_pkg::FW]}) begin
            ps_q[i]  <= mps_pkg::PS_LOST;
            to_run_q <= 8'h00;
          end
        end
        nsent_q[i]  <= cnt8(nsent_q[i], me && a_wd == mps_pkg::SLOT_STAT,
                            me_sel & lnk.rsp & (lnk.rsp_kind == mps_pkg::RSP_ERR));
        nrcvd_q[i]  <= cnt8(nrcvd_q[i], me && a_wd == mps_pkg::SLOT_STAT,
                            lnk.nak_up & (lnk.nak_up_addr == TW'(i)));
        seltmo_q[i] <= cnt8(seltmo_q[i], me && a_wd == mps_pkg::SLOT_STAT, f_to);
      end
    end
  end
endmodule : mps_ctl_end

/* design/mps_link_if.sv */
// shared line between control station and tributaries
interface mps_link_if;
  logic                      poll;
  logic [mps_pkg::TW-1:0]    poll_addr;
  logic                      tx_hold;
  logic                      nak_dn;
  logic [mps_pkg::TW-1:0]    nak_dn_addr;
  logic [7:0]                nak_dn_reason;
  logic                      rsp;
  logic [mps_pkg::TW-1:0]    rsp_addr;
  logic [1:0]                rsp_kind;
  logic [7:0]                rsp_reason;
  logic                      nak_up;
  logic [mps_pkg::TW-1:0]    nak_up_addr;
  logic [7:0]                nak_up_reason;

  modport ctl (output poll, poll_addr, tx_hold, nak_dn, nak_dn_addr, nak_dn_reason,
               input  rsp, rsp_addr, rsp_kind, rsp_reason, nak_up, nak_up_addr,
               nak_up_reason);
  modport trib (input  poll, poll_addr, tx_hold, nak_dn, nak_dn_addr, nak_dn_reason,
                output rsp, rsp_addr, rsp_kind, rsp_reason, nak_up, nak_up_addr,
                nak_up_reason);
endinterface : mps_link_if

/* design/mps_pkg.sv */
// shared constants and types of the multipoint poll scheduler
package mps_pkg;
  localparam int          N_TRIB      = 12;
  localparam int          TW          = 4;
  localparam int          CLK_MHZ     = 250;
  localparam int          TICK_US     = 1000;
  localparam int          TICK_CYC    = CLK_MHZ * TICK_US;
  localparam int          REPLY_NS    = 40;
  localparam int          REPLY_CYC   = (REPLY_NS * CLK_MHZ + 999) / 1000;
  localparam int          FW          = 8;
  // field positions inside a slot word
  localparam int          F_LVL0      = 0;
  localparam int          F_LVL1      = 8;
  localparam int          F_LVL2      = 16;
  localparam int          F_LVL3      = 24;
  localparam int          CTRL_EN     = 0;
  // urgency
  localparam logic [7:0]  URG_THR     = 8'h80;
  localparam logic [7:0]  URG_MAX     = 8'hff;
  // global timers, in ms
  localparam logic [15:0] DELTA_T_DEF = 16'h00c8;
  localparam logic [15:0] DELTA_T_MIN = 16'h00c8;
  localparam logic [15:0] PDLY_DEF    = 16'h0000;
  localparam logic [15:0] DEAD_T_DEF  = 16'h2710;
  localparam logic [15:0] SEL_TO_DEF  = 16'h0bb8;
  localparam logic        EN_DEF      = 1'b0;
  // per-tributary reset values {silent, idle, active}
  localparam logic [23:0] Q_DEF       = 24'h000000;
  localparam logic [23:0] R_DEF       = 24'h040820;
  // {to lost, to silent, to idle}
  localparam logic [23:0] LIM_DEF     = 24'h050304;
  // address map
  localparam logic [3:0]  REGION_SLOT = 4'h0;
  localparam logic [3:0]  REGION_GLB  = 4'h1;
  localparam logic [1:0]  SLOT_Q      = 2'h0;
  localparam logic [1:0]  SLOT_R      = 2'h1;
  localparam logic [1:0]  SLOT_LIM    = 2'h2;
  localparam logic [1:0]  SLOT_STAT   = 2'h3;
  localparam logic [11:0] G_CTRL      = 12'h100;
  localparam logic [11:0] G_DELTA     = 12'h104;
  localparam logic [11:0] G_PDLY      = 12'h108;
  localparam logic [11:0] G_DEAD      = 12'h10c;
  localparam logic [11:0] G_SELTO     = 12'h110;
  localparam logic [11:0] G_BUF       = 12'h114;
  localparam logic [11:0] G_STN       = 12'h118;
  localparam logic [11:0] G_SCHED     = 12'h11c;
  // reply kinds and nak reasons
  localparam logic [1:0]  RSP_NODATA  = 2'h0;
  localparam logic [1:0]  RSP_DATA    = 2'h1;
  localparam logic [1:0]  RSP_ERR     = 2'h2;
  localparam logic [7:0]  NAK_HDR     = 8'h01;
  localparam logic [7:0]  NAK_DATA    = 8'h02;

  typedef enum logic [3:0] {
    PS_ACTIVE = 4'h1,
    PS_IDLE   = 4'h2,
    PS_SILENT = 4'h4,
    PS_LOST   = 4'h8
  } mps_pstate_t;

  typedef enum logic [2:0] {
    SC_WAIT = 3'h1,
    SC_SEL  = 3'h2,
    SC_GAP  = 3'h4
  } mps_sched_t;

  typedef enum logic [1:0] {
    TR_IDLE = 2'h1,
    TR_TURN = 2'h2
  } mps_trst_t;
endpackage : mps_pkg

/* design/mps_trib_end.sv */
// tributary side of the line: answers polls, sends and counts naks
module mps_trib_end (
  // clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_resetn,
  // line
  mps_link_if.trib                          lnk,
  // per-tributary behaviour
  input  wire logic [mps_pkg::N_TRIB-1:0]   i_present,
  input  wire logic [mps_pkg::N_TRIB-1:0]   i_has_data,
  input  wire logic [mps_pkg::N_TRIB-1:0]   i_rx_err,
  input  wire logic [mps_pkg::N_TRIB-1:0]   i_tx_err,
  // counters and status
  output logic [mps_pkg::N_TRIB*8-1:0]      o_nak_sent_cnt,
  output logic [mps_pkg::N_TRIB*8-1:0]      o_nak_rcvd_cnt,
  output logic                              o_busy
);
  localparam int N  = mps_pkg::N_TRIB;
  localparam int TW = mps_pkg::TW;

  mps_pkg::mps_trst_t st_q;
  logic [TW-1:0]      addr_q;
  logic [7:0]         turn_q;
  logic               rsp_q, nak_q;
  logic [1:0]         kind_q;
  logic [7:0]         rsn_q;

  wire accept  = (st_q == mps_pkg::TR_IDLE) & lnk.poll & (lnk.poll_addr < TW'(N))
                 & i_present[lnk.poll_addr];
  wire turn_dn = (st_q == mps_pkg::TR_TURN) & (turn_q == 8'(mps_pkg::REPLY_CYC - 1));
  wire bad_rx  = accept & i_rx_err[lnk.poll_addr];

  assign lnk.rsp           = rsp_q;
  assign lnk.rsp_addr      = addr_q;
  assign lnk.rsp_kind      = kind_q;
  assign lnk.rsp_reason    = rsn_q;
  assign lnk.nak_up        = nak_q;
  assign lnk.nak_up_addr   = addr_q;
  assign lnk.nak_up_reason = mps_pkg::NAK_HDR;
  assign o_busy            = st_q == mps_pkg::TR_TURN;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q   <= mps_pkg::TR_IDLE;
      addr_q <= '0;
      turn_q <= 8'h00;
      rsp_q  <= 1'b0;
      nak_q  <= 1'b0;
      kind_q <= mps_pkg::RSP_NODATA;
      rsn_q  <= 8'h00;
    end else begin
      rsp_q <= 1'b0;
      nak_q <= bad_rx;
      case (st_q)
        mps_pkg::TR_IDLE: begin
          turn_q <= 8'h00;
          if (accept) begin
            addr_q <= lnk.poll_addr;
            st_q   <= mps_pkg::TR_TURN;
          end
        end
        mps_pkg::TR_TURN: begin
          turn_q <= turn_q + 8'h01;
          if (turn_dn) begin
            // reply deselects the tributary
            rsp_q  <= 1'b1;
            st_q   <= mps_pkg::TR_IDLE;
            kind_q <= i_tx_err[addr_q] ? mps_pkg::RSP_ERR
                    : (i_has_data[addr_q] && !i_rx_err[addr_q]) ? mps_pkg::RSP_DATA
                    : mps_pkg::RSP_NODATA;
            rsn_q  <= i_tx_err[addr_q] ? mps_pkg::NAK_DATA : 8'h00;
          end
        end
        default: st_q <= mps_pkg::TR_IDLE;
      endcase
    end
  end

  // per-tributary saturating nak counters
  for (genvar i = 0; i < N; i++) begin : g_cnt
    logic [7:0] sent_q, rcvd_q;
    wire        inc_s = nak_q & (addr_q == TW'(i));
    wire        inc_r = lnk.nak_dn & (lnk.nak_dn_addr == TW'(i));
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        sent_q <= 8'h00;
        rcvd_q <= 8'h00;
      end else begin
        if (inc_s && sent_q != 8'hff) sent_q <= sent_q + 8'h01;
        if (inc_r && rcvd_q != 8'hff) rcvd_q <= rcvd_q + 8'h01;
      end
    end
    assign o_nak_sent_cnt[i*8 +: 8] = sent_q;
    assign o_nak_rcvd_cnt[i*8 +: 8] = rcvd_q;
  end
endmodule : mps_trib_end

/* verification/mps_props.sv */
// link assertions for the poll scheduler
module mps_props (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  // link
  input wire logic       poll,
  input wire logic [3:0] poll_addr,
  input wire logic       tx_hold,
  input wire logic       nak_dn,
  input wire logic [3:0] nak_dn_addr,
  input wire logic [7:0] nak_dn_reason,
  input wire logic       rsp,
  input wire logic [3:0] rsp_addr,
  input wire logic [1:0] rsp_kind,
  input wire logic       nak_up,
  input wire logic [3:0] nak_up_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  chk_gap_quiet: assert property (tx_hold |-> !poll) else $error("poll in gap");
  chk_deselect_gap: assert property (rsp |=> !poll) else $error("poll at deselect");
  chk_one_select: assert property (poll |=> (!poll) [*8]) else $error("polls too close");
  chk_poll_range: assert property (poll |-> poll_addr < 4'hc) else $error("bad address");
  chk_reply_tie: assert property (rsp |-> $past(poll, 11)
    && rsp_addr == $past(poll_addr, 11)) else $error("reply not after poll");
  chk_err_nak: assert property (rsp && rsp_kind == 2'h2 && rsp_addr == poll_addr
    |=> nak_dn && nak_dn_addr == $past(rsp_addr)) else $error("no nak for error");
  chk_nak_cause: assert property (nak_dn |-> $past(rsp) && $past(rsp_kind) == 2'h2)
    else $error("nak without error");
  chk_nak_code: assert property (nak_dn |-> nak_dn_reason == mps_pkg::NAK_DATA)
    else $error("wrong nak reason");
  chk_hdr_nak: assert property (nak_up |-> $past(poll) && nak_up_addr == $past(poll_addr))
    else $error("nak not after poll");
endmodule : mps_props

/* verification/multipoint_poll_scheduler_test.sv */
// bench: control station and tributaries on one link
module multipoint_poll_scheduler_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        pready, perr, e, busy;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, q;
  logic [95:0] nsent, nrcvd;
  int          failures = 0, cmp_count = 0, gap;
  mps_link_if lnk ();
  mps_ctl_end #(.P_TICK_CYC(TK)) u_mps_ctl_end (.i_clk_sys(clk), .i_resetn(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(pready), .o_pslverr(perr), .lnk(lnk));
  mps_trib_end u_mps_trib_end (.i_clk_sys(clk), .i_resetn(rst_n), .lnk(lnk),
    .i_present(12'hfff), .i_has_data(12'hfff), .i_rx_err(12'h008), .i_tx_err(12'h020),
    .o_nak_sent_cnt(nsent), .o_nak_rcvd_cnt(nrcvd), .o_busy(busy));
  mps_props u_mps_props (.i_clk_sys(clk), .i_resetn(rst_n), .poll(lnk.poll),
    .poll_addr(lnk.poll_addr), .tx_hold(lnk.tx_hold), .nak_dn(lnk.nak_dn),
    .nak_dn_addr(lnk.nak_dn_addr), .rsp(lnk.rsp), .rsp_addr(lnk.rsp_addr),
    .rsp_kind(lnk.rsp_kind), .nak_up(lnk.nak_up), .nak_up_addr(lnk.nak_up_addr),
    .nak_dn_reason(lnk.nak_dn_reason));

  task automatic tally_and_finish(input bit hung);
    failures += hung;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) tally_and_finish(1'b1);
    {q, e} = {prd, perr};
    {psel, pen} <= 2'b00;
  endtask : apb

  task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(s, x, q);
  endtask : rd

  task automatic next_poll();
    gap = 0;
    do @(negedge clk); while (lnk.poll !== 1'b1 && ++gap < 40000);
    if (gap >= 40000) tally_and_finish(1'b1);
  endtask : next_poll

  task automatic t_defaults();
    rd("delta", 12'h104, 32'hc8);
    rd("poll delay", 12'h108, 32'h0);
    rd("dead period", 12'h10c, 32'h2710);
    apb(1'b1, 12'h104, 32'h64);
    rd("delta floor", 12'h104, 32'hc8);
    rd("unmapped", 12'h0cc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask : t_defaults

  // all active with equal defaults: consecutive polls, no spacing
  task automatic t_round();
    logic [3:0] p;
    apb(1'b1, 12'h100, 32'h1);
    next_poll();
    chk("first poll", 32'h1, {31'h0, gap >= 3 * 200 * TK});
    chk("first addr", 32'h0, {28'h0, lnk.poll_addr});
    @(negedge clk);
    chk("busy after poll", 32'h1, {31'h0, busy});
    p = lnk.poll_addr;
    for (int i = 1; i < 12; i++) begin
      next_poll();
      chk("next poll", {27'h0, (p == 4'hb ? 4'h0 : p + 4'h1), 1'b1},
          {27'h0, lnk.poll_addr, gap <= 24});
      p = lnk.poll_addr;
    end
  endtask : t_round

  task automatic t_delay();
    apb(1'b1, 12'h108, 32'h5);
    for (int i = 0; i < 12; i++) begin
      next_poll();
      if (i > 0) chk("poll gap", 32'h1, {31'h0, gap >= 11 + 5 * TK});
    end
  endtask : t_delay

  // two rounds done: tributary 3 sent two naks, tributary 5 got two
  task automatic t_counts();
    apb(1'b0, 12'h03c, 32'h0);
    chk("naks received", 32'h2, {24'h0, q[23:16]});
    apb(1'b0, 12'h05c, 32'h0);
    chk("naks sent", 32'h2, {24'h0, q[15:8]});
    chk("trib naks", 32'h0202, {16'h0, nsent[31:24], nrcvd[47:40]});
  endtask : t_counts

  // slot write lowers the idle limit; a buffer assignment restores active
  task automatic t_state();
    apb(1'b1, 12'h038, 32'h00050301);
    for (int i = 0; i < 12 && lnk.poll_addr !== 4'h3; i++) next_poll();
    repeat (12) @(posedge clk);
    rd("idle state", 12'h038, 32'h02050301);
    apb(1'b1, 12'h114, 32'h3);
    rd("buffer active", 12'h038, 32'h01050301);
  endtask : t_state

  initial forever #2 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_round();
    t_delay();
    t_counts();
    t_state();
    tally_and_finish(1'b0);
  end
endmodule : multipoint_poll_scheduler_test
